/* File: pdc_defines.svh */
// Purpose: Offsets, field positions, reset values and sizes of the PLL divider configuration
// Assumes: Register index times four gives the APB byte address
// Notes: Definitions only
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

`define PDC_IDX_PLL_CTRL 6'h10
`define PDC_IDX_REF_LOW 6'h11
`define PDC_IDX_REF_HIGH 6'h12
`define PDC_IDX_SWALLOW 6'h13
`define PDC_IDX_MAIN_LOW 6'h14
`define PDC_IDX_MAIN_HIGH 6'h15
`define PDC_IDX_LOOP_CTRL 6'h16
`define PDC_IDX_STATUS_SEL 6'h17
`define PDC_IDX_DIV_STATE 6'h18
`define PDC_IDX_STATUS_GATE 6'h1D

`define PDC_RST_PLL_CTRL 8'h7D
`define PDC_RST_REF_LOW 8'h01
`define PDC_RST_REF_HIGH 8'h00
`define PDC_RST_SWALLOW 8'h00
`define PDC_RST_MAIN_LOW 8'h03
`define PDC_RST_MAIN_HIGH 8'h00
`define PDC_RST_LOOP_CTRL 8'h06
`define PDC_RST_STATUS_SEL 8'h00
`define PDC_RST_STATUS_GATE 8'h00

`define PDC_BIT_MIDRAIL 7
`define PDC_BIT_RST_REF 6
`define PDC_BIT_RST_FB 5
`define PDC_BIT_RST_ALL 4
`define PDC_BIT_BYPASS 3
`define PDC_BIT_STATUS_GATE 7

`define PDC_REF_WIDTH 14
`define PDC_SWALLOW_WIDTH 6
`define PDC_MAIN_WIDTH 13
`define PDC_PRE_WIDTH 6

`define PDC_SEL_GROUND 6'h00
`define PDC_SEL_FB_OUT 6'h01
`define PDC_SEL_REF_OUT 6'h02
`define PDC_SEL_SWALLOW_OUT 6'h03
`define PDC_SEL_PRE_OUT 6'h04
`define PDC_SEL_SUPPLY 6'h30

`endif

/* File: pdc_pkg.sv */
// Purpose: Types and shared decode for the PLL divider configuration
// Assumes: pdc_defines.svh is on the include path
// Notes: Prescaler decode is used by the feedback divider only; the top uses the power mode type
`include "pdc_defines.svh"

package pdc_pkg;

  typedef enum logic [1:0] {
    PDC_PWR_NORMAL = 2'h0,
    PDC_PWR_ASYNC_DOWN = 2'h1,
    PDC_PWR_UNUSED = 2'h2,
    PDC_PWR_SYNC_DOWN = 2'h3
  } pdc_power_t;

  typedef logic [2:0] pdc_pre_code_t;

  // Lower modulus of the prescaler
  function automatic logic [`PDC_PRE_WIDTH-1:0] pdcPreModulus(input pdc_pre_code_t code);
    logic [`PDC_PRE_WIDTH-1:0] m;
    m = 6'h01;
    unique case (code)
      3'h0: m = 6'h01;
      3'h1: m = 6'h02;
      3'h2: m = 6'h02;
      3'h3: m = 6'h04;
      3'h4: m = 6'h08;
      3'h5: m = 6'h10;
      3'h6: m = 6'h20;
      3'h7: m = 6'h03;
    endcase
    return m;
  endfunction

  // Dual-modulus codes are 010 to 110
  function automatic logic pdcIsDualModulus(input pdc_pre_code_t code);
    return (code >= 3'h2) && (code <= 3'h6);
  endfunction

endpackage

/* File: pdc_ref_divider.sv */
// Purpose: Reference divider counting reference ticks
// Assumes: tick is a one-cycle enable on clk
// Notes: A divide value of zero acts as one
`timescale 1ns/100ps
`default_nettype none
`include "pdc_defines.svh"

module pdc_ref_divider #(
  parameter int WIDTH = `PDC_REF_WIDTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic tick,
  input wire logic [WIDTH-1:0] divide,
  output logic pulse
);
  import pdc_pkg::*;

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] last;

  assign last = (divide == '0) ? '0 : divide - WIDTH'(1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (tick) begin
      count_q <= (count_q >= last) ? '0 : count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse <= 1'b0;
    end else begin
      pulse <= !clear && tick && (count_q >= last);
    end
  end

endmodule
`default_nettype wire

/* File: pdc_feedback_divider.sv */
// Purpose: Feedback divider of prescaler, swallow counter and main counter
// Assumes: tick is a one-cycle enable on clk from the oscillator
// Notes: Ratio is lower modulus times main count (taken as one in bypass), plus swallow count in dual-modulus codes
`timescale 1ns/100ps
`default_nettype none
`include "pdc_defines.svh"

module pdc_feedback_divider #(
  parameter int SW_WIDTH = `PDC_SWALLOW_WIDTH,
  parameter int MAIN_WIDTH = `PDC_MAIN_WIDTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic tick,
  input wire pdc_pkg::pdc_pre_code_t preCode,
  input wire logic bypass,
  input wire logic [SW_WIDTH-1:0] swallow,
  input wire logic [MAIN_WIDTH-1:0] mainCount,
  output logic prePulse,
  output logic swallowPulse,
  output logic fbPulse
);
  import pdc_pkg::*;

  logic [`PDC_PRE_WIDTH-1:0] preCount_q;
  logic [SW_WIDTH-1:0] swCount_q;
  logic [MAIN_WIDTH-1:0] mainCount_q;
  logic dual;
  logic swallowing;
  logic [`PDC_PRE_WIDTH-1:0] preLast;
  logic [MAIN_WIDTH-1:0] mainLast;
  logic preWrap;
  logic mainWrap;

  assign dual = pdcIsDualModulus(preCode);
  assign swallowing = dual && (swallow != '0) && (swCount_q < swallow);
  assign preLast = swallowing ? pdcPreModulus(preCode) : pdcPreModulus(preCode) - 6'h01;
  assign mainLast = (bypass || mainCount == '0) ? '0 : mainCount - MAIN_WIDTH'(1);
  assign preWrap = tick && (preCount_q >= preLast);
  assign mainWrap = preWrap && (mainCount_q >= mainLast);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preCount_q <= '0;
    end else if (clear) begin
      preCount_q <= '0;
    end else if (tick) begin
      preCount_q <= preWrap ? '0 : preCount_q + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mainCount_q <= '0;
      swCount_q <= '0;
    end else if (clear || mainWrap) begin
      mainCount_q <= '0;
      swCount_q <= '0;
    end else if (preWrap) begin
      mainCount_q <= mainCount_q + MAIN_WIDTH'(1);
      swCount_q <= swallowing ? swCount_q + SW_WIDTH'(1) : swCount_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prePulse <= 1'b0;
      swallowPulse <= 1'b0;
      fbPulse <= 1'b0;
    end else begin
      prePulse <= !clear && preWrap;
      swallowPulse <= !clear && preWrap && swallowing && (swCount_q + SW_WIDTH'(1) == swallow);
      fbPulse <= !clear && mainWrap;
    end
  end

endmodule
`default_nettype wire

/* File: pdc_pll_config.sv */
// Purpose: APB register block and divider control of a PLL synthesizer
// Assumes: refIn and vcoIn are slow pins sampled by clk; zero-wait APB
// Notes: Byte address is register index times four
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pdc_defines.svh"

module pdc_pll_config (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic refIn,
  input wire logic vcoIn,
  output logic loopRunning,
  output logic powerDownAsync,
  output logic powerDownSync,
  output logic chargePumpMidrail,
  output logic refDivPulse,
  output logic fbDivPulse,
  output logic statusOut
);
  import pdc_pkg::*;

  logic [7:0] pllCtrl_q;
  logic [7:0] refLow_q;
  logic [7:0] refHigh_q;
  logic [7:0] swallow_q;
  logic [7:0] mainLow_q;
  logic [7:0] mainHigh_q;
  logic [7:0] loopCtrl_q;
  logic [7:0] statusSel_q;
  logic [7:0] statusGate_q;
  logic refTog_q;
  logic fbTog_q;
  logic [2:0] refSync_q;
  logic [2:0] vcoSync_q;
  logic [7:0] rdByte;
  logic mapped;
  logic wrEn;
  logic refTick;
  logic vcoTick;
  logic refClear;
  logic fbClear;
  logic refPulse;
  logic prePulse;
  logic swallowPulse;
  logic fbPulse;
  logic statusSig;
  pdc_power_t powerMode;

  function automatic logic isReg(input logic [7:0] addr, input logic [5:0] idx);
    return addr == {idx, 2'b00};
  endfunction

  assign mapped = isReg(paddr, `PDC_IDX_PLL_CTRL) || isReg(paddr, `PDC_IDX_REF_LOW)
    || isReg(paddr, `PDC_IDX_REF_HIGH) || isReg(paddr, `PDC_IDX_SWALLOW)
    || isReg(paddr, `PDC_IDX_MAIN_LOW) || isReg(paddr, `PDC_IDX_MAIN_HIGH)
    || isReg(paddr, `PDC_IDX_LOOP_CTRL) || isReg(paddr, `PDC_IDX_STATUS_SEL)
    || isReg(paddr, `PDC_IDX_DIV_STATE) || isReg(paddr, `PDC_IDX_STATUS_GATE);

  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign wrEn = psel && penable && pwrite && mapped;

  // PLL control byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pllCtrl_q <= `PDC_RST_PLL_CTRL;
    end else if (wrEn && isReg(paddr, `PDC_IDX_PLL_CTRL)) begin
      pllCtrl_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refLow_q <= `PDC_RST_REF_LOW;
    end else if (wrEn && isReg(paddr, `PDC_IDX_REF_LOW)) begin
      refLow_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refHigh_q <= `PDC_RST_REF_HIGH;
    end else if (wrEn && isReg(paddr, `PDC_IDX_REF_HIGH)) begin
      refHigh_q <= {2'b00, pwdata[5:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      swallow_q <= `PDC_RST_SWALLOW;
    end else if (wrEn && isReg(paddr, `PDC_IDX_SWALLOW)) begin
      swallow_q <= {2'b00, pwdata[5:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mainLow_q <= `PDC_RST_MAIN_LOW;
    end else if (wrEn && isReg(paddr, `PDC_IDX_MAIN_LOW)) begin
      mainLow_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mainHigh_q <= `PDC_RST_MAIN_HIGH;
    end else if (wrEn && isReg(paddr, `PDC_IDX_MAIN_HIGH)) begin
      mainHigh_q <= {3'b000, pwdata[4:0]};
    end
  end

  // Loop divider control byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loopCtrl_q <= `PDC_RST_LOOP_CTRL;
    end else if (wrEn && isReg(paddr, `PDC_IDX_LOOP_CTRL)) begin
      loopCtrl_q <= pwdata[7:0];
    end
  end

  // Status gate bit only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      statusGate_q <= `PDC_RST_STATUS_GATE;
    end else if (wrEn && isReg(paddr, `PDC_IDX_STATUS_GATE)) begin
      statusGate_q <= {pwdata[7], 7'h00};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      statusSel_q <= `PDC_RST_STATUS_SEL;
    end else if (wrEn && isReg(paddr, `PDC_IDX_STATUS_SEL)
        && !statusGate_q[`PDC_BIT_STATUS_GATE]) begin
      statusSel_q <= {pwdata[7:2], 2'b00};
    end
  end

  always_comb begin
    rdByte = 8'h00;
    if (isReg(paddr, `PDC_IDX_PLL_CTRL)) rdByte = pllCtrl_q;
    if (isReg(paddr, `PDC_IDX_REF_LOW)) rdByte = refLow_q;
    if (isReg(paddr, `PDC_IDX_REF_HIGH)) rdByte = refHigh_q;
    if (isReg(paddr, `PDC_IDX_SWALLOW)) rdByte = swallow_q;
    if (isReg(paddr, `PDC_IDX_MAIN_LOW)) rdByte = mainLow_q;
    if (isReg(paddr, `PDC_IDX_MAIN_HIGH)) rdByte = mainHigh_q;
    if (isReg(paddr, `PDC_IDX_LOOP_CTRL)) rdByte = loopCtrl_q;
    if (isReg(paddr, `PDC_IDX_STATUS_SEL)) rdByte = statusSel_q;
    if (isReg(paddr, `PDC_IDX_DIV_STATE)) rdByte = {5'h00, fbTog_q, refTog_q, loopRunning};
    if (isReg(paddr, `PDC_IDX_STATUS_GATE)) rdByte = statusGate_q;
  end

  // Read data captured in setup phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rdByte};
    end
  end

  // Pin synchronisers and edge detect
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refSync_q <= 3'h0;
      vcoSync_q <= 3'h0;
    end else begin
      refSync_q <= {refSync_q[1:0], refIn};
      vcoSync_q <= {vcoSync_q[1:0], vcoIn};
    end
  end

  assign refTick = refSync_q[1] && !refSync_q[2];
  assign vcoTick = vcoSync_q[1] && !vcoSync_q[2];

  assign powerMode = pdc_power_t'(pllCtrl_q[1:0]);
  assign refClear = !loopRunning || loopCtrl_q[`PDC_BIT_RST_REF] || loopCtrl_q[`PDC_BIT_RST_ALL];
  assign fbClear = !loopRunning || loopCtrl_q[`PDC_BIT_RST_FB] || loopCtrl_q[`PDC_BIT_RST_ALL];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loopRunning <= 1'b0;
      powerDownAsync <= 1'b1;
      powerDownSync <= 1'b0;
    end else begin
      loopRunning <= powerMode == PDC_PWR_NORMAL;
      powerDownAsync <= powerMode == PDC_PWR_ASYNC_DOWN;
      powerDownSync <= powerMode == PDC_PWR_SYNC_DOWN;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chargePumpMidrail <= 1'b0;
    end else begin
      chargePumpMidrail <= loopCtrl_q[`PDC_BIT_MIDRAIL];
    end
  end

  pdc_ref_divider #(
    .WIDTH(`PDC_REF_WIDTH)
  ) refDiv (
    .clk(clk),
    .rst_b(rst_b),
    .clear(refClear),
    .tick(refTick),
    .divide({refHigh_q[5:0], refLow_q}),
    .pulse(refPulse)
  );

  pdc_feedback_divider #(
    .SW_WIDTH(`PDC_SWALLOW_WIDTH),
    .MAIN_WIDTH(`PDC_MAIN_WIDTH)
  ) fbDiv (
    .clk(clk),
    .rst_b(rst_b),
    .clear(fbClear),
    .tick(vcoTick),
    .preCode(loopCtrl_q[2:0]),
    .bypass(loopCtrl_q[`PDC_BIT_BYPASS]),
    .swallow(swallow_q[5:0]),
    .mainCount({mainHigh_q[4:0], mainLow_q}),
    .prePulse(prePulse),
    .swallowPulse(swallowPulse),
    .fbPulse(fbPulse)
  );

  // Reference pulse and toggle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refDivPulse <= 1'b0;
      refTog_q <= 1'b0;
    end else begin
      refDivPulse <= refPulse;
      refTog_q <= refTog_q ^ refPulse;
    end
  end

  // Feedback pulse and toggle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fbDivPulse <= 1'b0;
      fbTog_q <= 1'b0;
    end else begin
      fbDivPulse <= fbPulse;
      fbTog_q <= fbTog_q ^ fbPulse;
    end
  end

  always_comb begin
    statusSig = 1'b0;
    unique case (statusSel_q[7:2])
      `PDC_SEL_FB_OUT: statusSig = fbPulse;
      `PDC_SEL_REF_OUT: statusSig = refPulse;
      `PDC_SEL_SWALLOW_OUT: statusSig = swallowPulse;
      `PDC_SEL_PRE_OUT: statusSig = prePulse;
      `PDC_SEL_SUPPLY: statusSig = 1'b1;
      default: statusSig = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      statusOut <= 1'b0;
    end else begin
      statusOut <= statusSig;
    end
  end

endmodule
`default_nettype wire

/* File: pdc_pll_config_checker.sv */
// Purpose: Port assertions for pdc_pll_config
// Assumes: Zero-wait APB, address is index times four
// Notes: Bound to every pdc_pll_config
`timescale 1ns/100ps
`default_nettype none
module pdc_pll_config_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic loopRunning,
  input wire logic powerDownAsync,
  input wire logic powerDownSync,
  input wire logic chargePumpMidrail,
  input wire logic refDivPulse,
  input wire logic fbDivPulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic acc;
  assign acc = psel && penable;
  AST_POWER_ONEHOT: assert property ($onehot0({loopRunning, powerDownAsync, powerDownSync}))
    else $error("power outputs overlap");
  AST_QUIET_DOWN: assert property (!loopRunning [*4] |-> !refDivPulse && !fbDivPulse)
    else $error("pulse while loop down");
  AST_MIDRAIL_SET: assert property (acc && pwrite && paddr == 8'h58 && pwdata[7] |-> ##[1:2] chargePumpMidrail)
    else $error("midrail not set");
  AST_MIDRAIL_CLR: assert property (acc && pwrite && paddr == 8'h58 && !pwdata[7] |-> ##[1:2] !chargePumpMidrail)
    else $error("midrail not cleared");
  AST_READY: assert property (acc |-> pready)
    else $error("no ready in access");
  AST_ERR_UNMAPPED: assert property (acc && paddr == 8'h80 |-> pslverr)
    else $error("no error on unmapped");
  AST_ERR_SOURCE: assert property (pslverr |-> acc)
    else $error("error outside access");
  AST_READ_UPPER: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_REF_ONE: assert property (refDivPulse |=> !refDivPulse)
    else $error("reference pulse too long");
  AST_FB_ONE: assert property (fbDivPulse |=> !fbDivPulse)
    else $error("feedback pulse too long");
  cover property (fbDivPulse);
  cover property (powerDownSync);
  cover property (acc && pslverr);
endmodule
bind pdc_pll_config pdc_pll_config_checker u_chk (.clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .loopRunning, .powerDownAsync,
  .powerDownSync, .chargePumpMidrail, .refDivPulse, .fbDivPulse);
`default_nettype wire

/* File: tb_pdc_pll_config.sv */
// Purpose: Self-checking bench for pdc_pll_config
// Assumes: Both pins toggle every 4 clocks
// Notes: Reads checked by a monitor against a queue
`timescale 1ns/100ps
`default_nettype none
module tb_pdc_pll_config;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, refIn = 0, vcoIn = 0;
  logic [7:0] paddr = 0, d;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, loopRunning, powerDownAsync, powerDownSync;
  logic chargePumpMidrail, refDivPulse, fbDivPulse, statusOut, sel, pulse;
  logic stat = 0;
  logic [32:0] expQ[$];
  logic [7:0] rv[8] = '{8'h7D, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h06, 8'h00};
  logic [7:0] mk[6] = '{8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'h1F};
  logic [2:0] pw[4] = '{3'b100, 3'b010, 3'b000, 3'b001};
  int ft[10][4] = '{'{0, 0, 5, 5}, '{1, 0, 5, 10}, '{7, 0, 5, 15}, '{15, 0, 5, 3},
    '{2, 0, 5, 10}, '{2, 2, 5, 12}, '{3, 1, 3, 13}, '{4, 1, 2, 17}, '{5, 1, 2, 33},
    '{6, 1, 2, 65}};
  int miscompares = 0, checks = 0, cyc = 0;
  assign pulse = stat ? statusOut : sel ? fbDivPulse : refDivPulse;
  always #10 clk = ~clk;
  pdc_pll_config u_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .refIn, .vcoIn, .loopRunning, .powerDownAsync, .powerDownSync,
    .chargePumpMidrail, .refDivPulse, .fbDivPulse, .statusOut);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    refIn <= cyc[2];
    vcoIn <= cyc[2];
  end
  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready)
      check("read", expQ.pop_front(), {pslverr, prdata});
  end
  task automatic apb(input logic [7:0] i, input logic w, input logic [7:0] v);
    psel <= 1;
    pwrite <= w;
    paddr <= {i[5:0], 2'b00};
    pwdata <= {24'h000000, v};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    apb(i, 1'b1, v);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic err);
    expQ.push_back({err, 24'h000000, e});
    apb(i, 1'b0, 8'h00);
  endtask
  task automatic period(input logic fb, input int ratio);
    time t;
    sel = fb;
    @(posedge pulse);
    @(posedge pulse);
    t = $time;
    @(posedge pulse);
    check("period", 33'(ratio * 8), 33'(($time - t) / 20));
  endtask
  task automatic quiet(input logic fb);
    int n;
    n = 0;
    sel = fb;
    repeat (4) @(posedge clk);
    repeat (300) @(posedge clk) n += int'(pulse);
    check("held", 33'h0, 33'(n));
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1ms;
    miscompares++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'h06d401cb));
    repeat (12) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    for (int k = 0; k < 8; k++) rd(8'h10 + 8'(k), rv[k], 1'b0);
    for (int k = 1; k < 6; k++) begin
      d = 8'($urandom);
      wr(8'h10 + 8'(k), d);
      rd(8'h10 + 8'(k), d & mk[k], 1'b0);
    end
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00, 1'b1);
    wr(8'h1D, 8'h80);
    rd(8'h1D, 8'h80, 1'b0);
    wr(8'h17, 8'h04);
    rd(8'h17, 8'h00, 1'b0);
    wr(8'h1D, 8'h00);
    wr(8'h17, 8'hC0);
    rd(8'h17, 8'hC0, 1'b0);
    check("status", 33'h1, 33'(statusOut));
    for (int k = 0; k < 4; k++) begin
      wr(8'h10, 8'h7C | 8'(k));
      repeat (2) @(posedge clk);
      check("power", 33'(pw[k]), 33'({loopRunning, powerDownAsync, powerDownSync}));
    end
    wr(8'h10, 8'h7C);
    wr(8'h11, 8'h03);
    wr(8'h12, 8'h00);
    wr(8'h15, 8'h00);
    wr(8'h16, 8'h86);
    @(negedge clk);
    check("midrail", 33'h1, 33'(chargePumpMidrail));
    period(1'b0, 3);
    wr(8'h13, 8'h00);
    wr(8'h14, 8'h01);
    wr(8'h16, 8'h16);
    quiet(1'b0);
    quiet(1'b1);
    wr(8'h16, 8'h26);
    quiet(1'b1);
    period(1'b0, 3);
    for (int k = 0; k < 10; k++) begin
      wr(8'h13, 8'(ft[k][1]));
      wr(8'h14, 8'(ft[k][2]));
      wr(8'h16, 8'(ft[k][0]));
      period(1'b1, ft[k][3]);
    end
    wr(8'h17, 8'h04);
    stat = 1;
    period(1'b1, 65);
    wr(8'h17, 8'h08);
    period(1'b0, 3);
    check("queue", 33'h0, 33'(expQ.size()));
    give_verdict;
  end
endmodule
`default_nettype wire
